// ---- verilog/pcr_pkg.sv ----
// constants, types and helpers for the per-port clock recovery block
package pcr_pkg;
  // ----------------------------------------------------------------
  // register map (word indices within a bank, avalon address bits 4:2)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [1:0] BANK_PORT = 2'h0;
  localparam logic [1:0] BANK_GLOBAL = 2'h1;
  localparam logic [2:0] REG_DOWN_CFG = 3'h0;
  localparam logic [2:0] REG_AVG_FILL = 3'h1;
  localparam logic [2:0] REG_SHIFT = 3'h2;
  localparam logic [2:0] REG_INIT_FREE = 3'h3;
  localparam logic [2:0] REG_LOCK_THR = 3'h4;
  localparam logic [2:0] REG_LOOP_STAT = 3'h5;
  localparam logic [2:0] REG_OOL_STAT = 3'h6;
  localparam logic [2:0] REG_INV_CNT = 3'h7;
  localparam logic [2:0] REG_REC_CFG = 3'h0;
  localparam logic [2:0] REG_IRQ_STAT = 3'h1;
  localparam logic [2:0] REG_IRQ_CLR = 3'h2;
  localparam logic [2:0] REG_IRQ_EN = 3'h3;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CFG_PWD = 0;
  localparam int CFG_SRT = 1;
  localparam int CFG_ACM = 2;
  localparam int CFG_TUR_LSB = 4;
  localparam int TUR_W = 12;
  localparam int THR_W = 5;
  localparam int THR_TS_LSB = 0;
  localparam int THR_FILT_LSB = 8;
  localparam int THR_ACM_LSB = 16;
  localparam int RCFG_IFC_PD = 0;
  localparam int RCFG_OFF = 1;
  localparam int OOL_TS = 0;
  localparam int OOL_FILT = 1;
  localparam int OOL_ACM = 2;
  // ----------------------------------------------------------------
  // reset values and loop constants
  // ----------------------------------------------------------------
  localparam logic [15:0] RST_DOWN_CFG = 16'h0001;
  localparam logic [3:0] RST_SHIFT = 4'h4;
  localparam logic [20:0] RST_LOCK_THR = 21'h000000;
  localparam int WIN_LEN = 16;
  localparam int WW = 20;
  localparam int PPM_LSB = 16;
  localparam int FILT_RANGE_PPM = 240;
  localparam logic [WW-1:0] FILT_LIMIT = WW'(FILT_RANGE_PPM * PPM_LSB);
  localparam int FILT_SHIFT = 3;
  localparam logic [WW-1:0] FILT_LOCK_ERR = 20'h00100;
  localparam logic [3:0] TS_NOMINAL = 4'h0;
  localparam int TS_WINDOW = 3;
  localparam int TS_GAIN_SHIFT = 4;
  localparam int FREE_MULT_SHIFT = 3;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic starting;
    logic invalid;
    logic valid;
    logic [3:0] value;
  } pcr_ts_s;
  typedef struct packed {
    logic restart;
    logic valid;
    logic [15:0] level;
  } pcr_fill_s;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic signed [WW-1:0] pcr_clip(input logic signed [WW-1:0] v,
                                                   input logic [WW-1:0] lim);
    logic signed [WW-1:0] l;
    l = $signed(lim);
    if (v > l) begin
      pcr_clip = l;
    end else if (v < -l) begin
      pcr_clip = -l;
    end else begin
      pcr_clip = v;
    end
  endfunction
  function automatic logic pcr_judge(input logic [THR_W-1:0] cnt,
                                     input logic [THR_W-1:0] thr);
    pcr_judge = cnt > thr;
  endfunction
endpackage

// ---- verilog/pcr_port_recovery.sv ----
// per-port clock recovery loops with avalon-mm register slave
//
// How it works
// - port power-down bit stops that port's loops
// - interface power-down bit blocks time-stamp and fill inputs; data ticks still pass
// - global off bit sticks until device reset
// - time-stamp, adaptive, filter loops; srt/acm select sources
// - out-of-window value: holdover, flag, count invalid
// - time-stamp out-of-lock over 16 periods vs threshold
// - fifo start-up: time-stamp loop free runs, flag
// - filter clipped to 240 ppm, smooths sources
// - filter lock losses over 16 periods vs threshold
// - fill minus target, shifted, second order loop
// - clip to tuning range, set max-deviation flag
// - adaptive out-of-range count per 16 cells
// - adaptive free run 8 x initial field data ticks
// - initial field two bits wider than start fill
//
// Local design decisions: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module pcr_port_recovery
  import pcr_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int START_FILL_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire pcr_ts_s [NPORTS-1:0] ts_i,
  input wire pcr_fill_s [NPORTS-1:0] fill_i,
  input wire logic [NPORTS-1:0] data_tick_i,
  output logic [NPORTS-1:0][15:0] dco_ctrl_o,
  output logic [NPORTS-1:0] port_active_o,
  output logic irq_o
);
  localparam int TINI_W = START_FILL_W + 2;
  localparam int FR_W = TINI_W + FREE_MULT_SHIFT;

  if (NPORTS < 1 || NPORTS > 32) begin : g_chk_ports
    $error("NPORTS must be 1 to 32");
  end
  if (START_FILL_W < 1 || TINI_W > 16) begin : g_chk_fill
    $error("START_FILL_W must be 1 to 14");
  end

  // ----------------------------------------------------------------
  // bus slave and global state
  // ----------------------------------------------------------------
  logic ack, next_ack;
  logic [31:0] rdata, next_rdata;
  logic ifc_pd, next_ifc_pd;
  logic gl_off, next_gl_off;
  logic [NPORTS-1:0] irq_stat, next_irq_stat, irq_en, next_irq_en;
  logic [NPORTS-1:0] ool_rise;
  logic [NPORTS-1:0][31:0] port_rd;
  logic wr_go;
  logic [1:0] bank;
  logic [4:0] sel_port;
  logic [2:0] sel_reg;

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign avs_readdata_o = rdata;
  assign irq_o = |(irq_stat & irq_en);
  assign wr_go = avs_write_i & ack;
  assign bank = avs_address_i[11:10];
  assign sel_port = avs_address_i[9:5];
  assign sel_reg = avs_address_i[4:2];

  always_comb begin
    next_ack = (avs_read_i | avs_write_i) & ~ack;
    next_rdata = rdata;
    next_ifc_pd = ifc_pd;
    next_gl_off = gl_off;
    next_irq_en = irq_en;
    next_irq_stat = irq_stat;
    if (avs_read_i && !ack) begin
      next_rdata = 32'h0000_0000;
      if (bank == BANK_PORT && 32'(sel_port) < NPORTS) begin
        next_rdata = port_rd[sel_port];
      end else if (bank == BANK_GLOBAL) begin
        unique case (sel_reg)
          REG_REC_CFG: next_rdata = 32'({gl_off, ifc_pd});
          REG_IRQ_STAT: next_rdata = 32'(irq_stat);
          REG_IRQ_EN: next_rdata = 32'(irq_en);
          default: next_rdata = 32'h0000_0000;
        endcase
      end
    end
    if (wr_go && bank == BANK_GLOBAL) begin
      unique case (sel_reg)
        REG_REC_CFG: begin
          next_ifc_pd = avs_writedata_i[RCFG_IFC_PD];
          next_gl_off = gl_off | avs_writedata_i[RCFG_OFF];
        end
        REG_IRQ_CLR: next_irq_stat = irq_stat & ~avs_writedata_i[NPORTS-1:0];
        REG_IRQ_EN: next_irq_en = avs_writedata_i[NPORTS-1:0];
        default: next_ack = next_ack;
      endcase
    end
    next_irq_stat = next_irq_stat | ool_rise;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
      rdata <= 32'h0000_0000;
      ifc_pd <= 1'b0;
      gl_off <= 1'b0;
      irq_stat <= '0;
      irq_en <= '0;
    end else begin
      ack <= next_ack;
      rdata <= next_rdata;
      ifc_pd <= next_ifc_pd;
      gl_off <= next_gl_off;
      irq_stat <= next_irq_stat;
      irq_en <= next_irq_en;
    end
  end

  // ----------------------------------------------------------------
  // per-port loops
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic [15:0] cfg, next_cfg, avg, next_avg, inv_cnt, next_inv_cnt;
    logic [3:0] shf, next_shf;
    logic [TINI_W-1:0] tini, next_tini;
    logic [20:0] thr, next_thr;
    logic [31:0] rd_word;
    logic signed [WW-1:0] ts_freq, next_ts_freq, acm_int, next_acm_int;
    logic signed [WW-1:0] acm_out, next_acm_out, filt, next_filt;
    logic hov, next_hov, frr, next_frr, maxd, next_maxd;
    logic [FR_W-1:0] fr_cnt, next_fr_cnt;
    logic [3:0] ts_per, next_ts_per, cell_cnt, next_cell_cnt;
    logic [THR_W-1:0] ts_ev, next_ts_ev, fl_ev, next_fl_ev, acm_ev, next_acm_ev;
    logic [2:0] ool, next_ool;
    logic act, wr_hit, tsv, cellv, ts_wrap;
    logic signed [WW-1:0] err, diff, scaled, req, src, step;
    logic [WW-1:0] tur_lim;

    assign act = !cfg[CFG_PWD] && !gl_off;
    assign port_active_o[p] = act;
    assign wr_hit = wr_go && bank == BANK_PORT && 32'(sel_port) == p;
    assign tsv = ts_i[p].valid && act && !ifc_pd && cfg[CFG_SRT];
    assign cellv = fill_i[p].valid && act && !ifc_pd && cfg[CFG_ACM];
    assign ts_wrap = tsv && !ts_i[p].starting && ts_per == 4'(WIN_LEN - 1);
    assign tur_lim = WW'(cfg[CFG_TUR_LSB +: TUR_W]);
    assign dco_ctrl_o[p] = filt[15:0];
    assign ool_rise[p] = |(next_ool & ~ool);
    assign port_rd[p] = rd_word;

    always_comb begin
      unique case (sel_reg)
        REG_DOWN_CFG: rd_word = 32'(cfg);
        REG_AVG_FILL: rd_word = 32'(avg);
        REG_SHIFT: rd_word = 32'(shf);
        REG_INIT_FREE: rd_word = 32'(tini);
        REG_LOCK_THR: rd_word = 32'(thr) & 32'h001F_1F1F;
        REG_LOOP_STAT: rd_word = 32'({fr_cnt != '0, maxd, frr, hov});
        REG_OOL_STAT: rd_word = 32'(ool);
        REG_INV_CNT: rd_word = 32'(inv_cnt);
      endcase
    end

    always_comb begin
      next_cfg = cfg;
      next_avg = avg;
      next_shf = shf;
      next_tini = tini;
      next_thr = thr;
      next_inv_cnt = inv_cnt;
      next_ts_freq = ts_freq;
      next_acm_int = acm_int;
      next_acm_out = acm_out;
      next_filt = filt;
      next_hov = hov;
      next_frr = frr;
      next_maxd = maxd;
      next_fr_cnt = fr_cnt;
      next_ts_per = ts_per;
      next_cell_cnt = cell_cnt;
      next_ts_ev = ts_ev;
      next_fl_ev = fl_ev;
      next_acm_ev = acm_ev;
      next_ool = ool;
      err = WW'($signed(ts_i[p].value - TS_NOMINAL));
      diff = $signed(WW'(fill_i[p].level)) - $signed(WW'(avg));
      scaled = diff >>> shf;
      req = pcr_clip(acm_int + scaled, FILT_LIMIT);
      src = (cfg[CFG_SRT] ? ts_freq : '0) + (cfg[CFG_ACM] ? acm_out : '0);
      step = (src - filt) >>> FILT_SHIFT;
      if (wr_hit) begin
        unique case (sel_reg)
          REG_DOWN_CFG: next_cfg = avs_writedata_i[15:0];
          REG_AVG_FILL: next_avg = avs_writedata_i[15:0];
          REG_SHIFT: next_shf = avs_writedata_i[3:0];
          REG_INIT_FREE: next_tini = avs_writedata_i[TINI_W-1:0];
          REG_LOCK_THR: next_thr = avs_writedata_i[20:0];
          REG_INV_CNT: next_inv_cnt = 16'h0000;
          default: next_thr = thr;
        endcase
      end
      if (!act) begin
        next_ts_freq = '0;
        next_acm_int = '0;
        next_acm_out = '0;
        next_filt = '0;
        next_hov = 1'b0;
        next_frr = 1'b0;
        next_maxd = 1'b0;
        next_ts_per = '0;
        next_cell_cnt = '0;
        next_ts_ev = '0;
        next_fl_ev = '0;
        next_acm_ev = '0;
        next_fr_cnt = FR_W'({tini, 3'h0});
      end else begin
        // time-stamp loop
        if (ts_i[p].starting && !ifc_pd && cfg[CFG_SRT]) begin
          next_frr = 1'b1;
          next_ts_freq = '0;
          next_hov = 1'b0;
        end else if (tsv) begin
          next_frr = 1'b0;
          next_ts_per = ts_per + 4'h1;
          if (ts_i[p].invalid || err > TS_WINDOW || err < -TS_WINDOW) begin
            next_hov = 1'b1;
            next_inv_cnt = inv_cnt + 16'h0001;
            next_ts_ev = ts_ev + 5'h01;
          end else begin
            next_hov = 1'b0;
            next_ts_freq = pcr_clip(ts_freq + (err <<< TS_GAIN_SHIFT), FILT_LIMIT);
          end
        end
        // filter loop
        if (data_tick_i[p]) begin
          next_filt = pcr_clip(filt + step, FILT_LIMIT);
          if (pcr_clip(src - filt, FILT_LOCK_ERR) != src - filt) begin
            next_fl_ev = fl_ev + 5'h01;
          end
        end
        if (ts_wrap) begin
          next_ool[OOL_TS] = pcr_judge(next_ts_ev, thr[THR_TS_LSB +: THR_W]);
          next_ool[OOL_FILT] = pcr_judge(next_fl_ev, thr[THR_FILT_LSB +: THR_W]);
          next_ts_ev = '0;
          next_fl_ev = '0;
        end
        // adaptive loop
        if (fill_i[p].restart && !ifc_pd) begin
          next_fr_cnt = FR_W'({tini, 3'h0});
          next_acm_int = '0;
          next_acm_out = '0;
        end else if (fr_cnt != '0) begin
          if (data_tick_i[p]) begin
            next_fr_cnt = fr_cnt - FR_W'(1);
          end
        end else if (cellv) begin
          next_acm_int = req;
          next_acm_out = pcr_clip(req + scaled, tur_lim);
          next_maxd = pcr_clip(req + scaled, tur_lim) != req + scaled;
          next_cell_cnt = cell_cnt + 4'h1;
          if (next_maxd) begin
            next_acm_ev = acm_ev + 5'h01;
          end
          if (cell_cnt == 4'(WIN_LEN - 1)) begin
            next_ool[OOL_ACM] = pcr_judge(next_acm_ev, thr[THR_ACM_LSB +: THR_W]);
            next_acm_ev = '0;
          end
        end
      end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cfg <= RST_DOWN_CFG;
        avg <= 16'h0000;
        shf <= RST_SHIFT;
        tini <= '0;
        thr <= RST_LOCK_THR;
        inv_cnt <= 16'h0000;
        ts_freq <= '0;
        acm_int <= '0;
        acm_out <= '0;
        filt <= '0;
        hov <= 1'b0;
        frr <= 1'b0;
        maxd <= 1'b0;
        fr_cnt <= '0;
        ts_per <= 4'h0;
        cell_cnt <= 4'h0;
        ts_ev <= '0;
        fl_ev <= '0;
        acm_ev <= '0;
        ool <= 3'h0;
      end else begin
        cfg <= next_cfg;
        avg <= next_avg;
        shf <= next_shf;
        tini <= next_tini;
        thr <= next_thr;
        inv_cnt <= next_inv_cnt;
        ts_freq <= next_ts_freq;
        acm_int <= next_acm_int;
        acm_out <= next_acm_out;
        filt <= next_filt;
        hov <= next_hov;
        frr <= next_frr;
        maxd <= next_maxd;
        fr_cnt <= next_fr_cnt;
        ts_per <= next_ts_per;
        cell_cnt <= next_cell_cnt;
        ts_ev <= next_ts_ev;
        fl_ev <= next_fl_ev;
        acm_ev <= next_acm_ev;
        ool <= next_ool;
      end
    end
  end
endmodule
`default_nettype wire

// ---- verification/pcr_far_model.sv ----
// far side model: time-stamp fifo output, fill reports and data ticks
`timescale 1ns/1ns
`default_nettype none
module pcr_far_model
  import pcr_pkg::*;
#(
  parameter int NPORTS = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire pcr_ts_s ts_req_i,
  input wire pcr_fill_s fill_req_i,
  input wire logic tick_req_i,
  output var pcr_ts_s [NPORTS-1:0] ts_o,
  output var pcr_fill_s [NPORTS-1:0] fill_o,
  output logic [NPORTS-1:0] data_tick_o
);
  pcr_ts_s ts_q;
  pcr_ts_s next_ts;
  pcr_fill_s fill_q;
  pcr_fill_s next_fill;
  logic tick_q;
  always_comb begin
    next_ts = ts_req_i;
    next_fill = fill_req_i;
    // idle data lines toggle so stale values never look valid
    if (!ts_req_i.valid) begin
      next_ts.value = ~ts_q.value;
    end
    if (!fill_req_i.valid) begin
      next_fill.level = ~fill_q.level;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ts_q <= '0;
      fill_q <= '0;
      tick_q <= 1'b0;
    end else begin
      ts_q <= next_ts;
      fill_q <= next_fill;
      tick_q <= tick_req_i;
    end
  end
  assign ts_o = {NPORTS{ts_q}};
  assign fill_o = {NPORTS{fill_q}};
  assign data_tick_o = {NPORTS{tick_q}};
endmodule
`default_nettype wire

// ---- verification/pcr_port_recovery_chk.sv ----
// port-level assertions for the per-port clock recovery block
`timescale 1ns/1ns
`default_nettype none
module pcr_port_recovery_chk
  import pcr_pkg::*;
#(
  parameter int NPORTS = 8,
  parameter int START_FILL_W = 8
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire pcr_ts_s [NPORTS-1:0] ts_i,
  input wire pcr_fill_s [NPORTS-1:0] fill_i,
  input wire logic [NPORTS-1:0] data_tick_i,
  input wire logic [NPORTS-1:0][15:0] dco_ctrl_o,
  input wire logic [NPORTS-1:0] port_active_o,
  input wire logic irq_o
);
  logic off_seen;
  logic next_off_seen;
  logic wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o;
  always_comb begin
    next_off_seen = off_seen;
    if (wr_ok && avs_address_i == 12'h400 && avs_writedata_i[RCFG_OFF]) begin
      next_off_seen = 1'b1;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      off_seen <= 1'b0;
    end else begin
      off_seen <= next_off_seen;
    end
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_req_rise;
    $rose(avs_read_i || avs_write_i);
  endsequence
  sequence s_cfg0_wr(logic d);
    wr_ok && avs_address_i == 12'h000 && avs_writedata_i[CFG_PWD] == d;
  endsequence
  a_wait_first: assert property (s_req_rise |-> avs_waitrequest_o)
    else $error("waitrequest low in first request cycle");
  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("more than one wait cycle");
  a_rdata_hold: assert property ($changed(avs_readdata_o)
    |-> $past(avs_read_i && avs_waitrequest_o)) else $error("read data moved");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o
    && avs_address_i[11] |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_port_down: assert property (s_cfg0_wr(1'b1) |=> !port_active_o[0])
    else $error("port active after power-down");
  a_port_up: assert property (s_cfg0_wr(1'b0) and !off_seen |=> port_active_o[0])
    else $error("port not active after power-up");
  a_off_sticky: assert property (off_seen |-> port_active_o == '0)
    else $error("port active after global off");
  a_irq_mask: assert property (wr_ok && avs_address_i == 12'h40C
    && avs_writedata_i[NPORTS-1:0] == '0 |=> !irq_o) else $error("irq while masked");
  a_dco_limit: assert property ($signed(dco_ctrl_o[0]) <= 16'sd3840
    && $signed(dco_ctrl_o[0]) >= -16'sd3840) else $error("dco beyond filter range");
endmodule
bind pcr_port_recovery pcr_port_recovery_chk #(
  .NPORTS(NPORTS),
  .START_FILL_W(START_FILL_W)
) chk_inst (
  .clk_sys_i(clk_sys_i),
  .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .ts_i(ts_i),
  .fill_i(fill_i),
  .data_tick_i(data_tick_i),
  .dco_ctrl_o(dco_ctrl_o),
  .port_active_o(port_active_o),
  .irq_o(irq_o)
);
`default_nettype wire

// ---- verification/tb_top.sv ----
// self-checking testbench for the per-port clock recovery block
`timescale 1ns/1ns
`default_nettype none
`define CK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top
  import pcr_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [ADDR_W-1:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  pcr_ts_s ts_req = '0;
  pcr_fill_s fill_req = '0;
  logic tick_req = 1'b0;
  pcr_ts_s [1:0] ts_w;
  pcr_fill_s [1:0] fill_w;
  logic [1:0] tick_w;
  logic [1:0][15:0] dco_ctrl_o;
  logic [1:0] port_active_o;
  logic irq_o;
  logic st = 1'b0;
  logic [31:0] q;
  int bad_count = 0;
  int check_count = 0;
  always #2 clk_sys_i = ~clk_sys_i;
  pcr_far_model #(.NPORTS(2)) pcr_far_model_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .ts_req_i(ts_req), .fill_req_i(fill_req), .tick_req_i(tick_req), .ts_o(ts_w),
    .fill_o(fill_w), .data_tick_o(tick_w));
  pcr_port_recovery #(.NPORTS(2), .START_FILL_W(8)) pcr_port_recovery_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .ts_i(ts_w),
    .fill_i(fill_w), .data_tick_i(tick_w), .dco_ctrl_o(dco_ctrl_o),
    .port_active_o(port_active_o), .irq_o(irq_o));
  // ----------------------------------------------------------------
  // bus and link tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CK(q & m, e)
  endtask
  task automatic ts_send(input logic [3:0] v, input logic bad);
    @(posedge clk_sys_i);
    ts_req <= '{st, bad, 1'b1, v};
    @(posedge clk_sys_i);
    ts_req <= '{st, 1'b0, 1'b0, 4'h0};
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  // k: 0 data tick, 1 cell, 2 restart
  task automatic fl(input int k, input logic [15:0] lvl);
    @(posedge clk_sys_i);
    fill_req <= '{k == 2, k == 1, lvl};
    tick_req <= (k == 0);
    @(posedge clk_sys_i);
    fill_req <= '0;
    tick_req <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic ts_win(input int n, input int nb);
    int k;
    for (int i = 0; i < n; i++) begin
      k = $urandom_range(0, 6);
      ts_send((i < nb) ? 4'($urandom_range(4, 12)) : 4'(k > 3 ? k + 9 : k), 1'b0);
    end
  endtask
  function automatic logic exp_ool(input int nb, input int thr);
    return nb > thr;
  endfunction
  task automatic stop_test();
    if (bad_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    stop_test();
  end
  initial begin
    void'($urandom(32'h2d48));
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    rd(12'h000, 32'hFFFF, 32'h1);
    rd(12'h008, 32'hF, 32'h4);
    rd(12'h010, 32'hFFFFFFFF, 32'h0);
    `CK(port_active_o, 2'b00)
    wr(12'h010, 32'h1F02);
    wr(12'h40C, 32'h1);
    wr(12'h000, 32'h102);
    `CK(port_active_o, 2'b01)
    st = 1'b1;
    ts_send(4'h1, 1'b0);
    rd(12'h014, 32'h2, 32'h2);
    rd(12'h01C, 32'hFFFF, 32'h0);
    st = 1'b0;
    ts_send(4'h5, 1'b0);
    rd(12'h014, 32'h3, 32'h1);
    ts_send(4'h0, 1'b1);
    rd(12'h01C, 32'hFFFF, 32'h2);
    ts_send(4'h1, 1'b0);
    rd(12'h014, 32'h1, 32'h0);
    ts_win(13, 1);
    rd(12'h018, 32'h3, {31'h0, exp_ool(3, 2)});
    `CK(irq_o, 1'b1)
    wr(12'h408, 32'h1);
    rd(12'h404, 32'h3, 32'h0);
    ts_win(16, 2);
    rd(12'h018, 32'h3, {31'h0, exp_ool(2, 2)});
    wr(12'h01C, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(12'h400, 32'(k == 0));
      wr(12'h000, (k == 0) ? 32'h102 : 32'h100);
      ts_send(4'h8, 1'b0);
      rd(12'h01C, 32'hFFFF, 32'h0);
    end
    wr(12'h000, 32'h104);
    wr(12'h004, 32'd100);
    wr(12'h008, 32'h0);
    wr(12'h00C, 32'hFFFFFFFF);
    rd(12'h00C, 32'hFFFFFFFF, 32'h3FF);
    wr(12'h00C, 32'h2);
    fl(2, 16'h0);
    repeat (15) fl(0, 16'h0);
    rd(12'h014, 32'h8, 32'h8);
    fl(0, 16'h0);
    rd(12'h014, 32'h8, 32'h0);
    repeat (16) fl(1, 16'(100 + $urandom_range(50, 200)));
    rd(12'h014, 32'h4, 32'h4);
    rd(12'h018, 32'h4, {29'h0, exp_ool(16, 0), 2'b00});
    repeat (4) fl(0, 16'h0);
    `CK($signed(dco_ctrl_o[0]) > 16'sd0 && $signed(dco_ctrl_o[0]) <= 16'sd16, 1'b1)
    `CK(irq_o, 1'b1)
    wr(12'h40C, 32'h0);
    `CK(irq_o, 1'b0)
    wr(12'h000, 32'h106);
    wr(12'h008, 32'hF);
    rd(12'h008, 32'hF, 32'hF);
    wr(12'h400, 32'h2);
    `CK(port_active_o, 2'b00)
    wr(12'h400, 32'h0);
    wr(12'h000, 32'h104);
    `CK(port_active_o, 2'b00)
    rd(12'h400, 32'h2, 32'h2);
    rd(12'hC00, 32'hFFFFFFFF, 32'h0);
    stop_test();
  end
endmodule
`default_nettype wire
